//--- fsw_pkg.sv
// Shared constants, types and register map of the output watchdog block
package fsw_pkg;

   // ----------------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam logic [7:0] REG_WD_MULT = 8'h00;
   localparam logic [7:0] REG_LINK_WD_TIME = 8'h04;
   localparam logic [7:0] REG_LOCAL_WD_TIME = 8'h08;
   localparam logic [7:0] REG_STATE_REQ = 8'h0c;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_INPUT_IMAGE = 8'h14;

   // Status field layout
   localparam int unsigned ST_CODE_LSB = 0;
   localparam int unsigned ST_CODE_W = 4;
   localparam int unsigned ST_LINK_TRIP_BIT = 4;
   localparam int unsigned ST_LOCAL_TRIP_BIT = 5;
   localparam int unsigned ST_REFUSED_BIT = 6;

   // Node state codes as seen by software
   localparam logic [3:0] CODE_INIT = 4'h1;
   localparam logic [3:0] CODE_PREP = 4'h2;
   localparam logic [3:0] CODE_BOOT = 4'h3;
   localparam logic [3:0] CODE_GUARD = 4'h4;
   localparam logic [3:0] CODE_RUN = 4'h8;

   // ----------------------------------------------------------------
   // Watchdog timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned BASE_FREQ_MHZ = 25;
   localparam int unsigned BASE_PERIOD_NS = 1000 / BASE_FREQ_MHZ;
   localparam logic [17:0] HALF_BASE_PER_CLK = 18'(2 * CLK_PERIOD_NS / BASE_PERIOD_NS);
   localparam logic [17:0] HALF_TICK_EXTRA = 18'h4;
   localparam int unsigned WD_TIMEOUT_MS = 100;
   localparam logic [15:0] DEF_WD_MULT = 16'h09c2;
   localparam logic [15:0] DEF_LINK_WD_TIME = 16'h03e8;
   localparam logic [15:0] DEF_LOCAL_WD_TIME = 16'h03e8;
   localparam logic [15:0] MIN_WD_MULT = 16'h0001;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      ND_INIT,
      ND_PREP,
      ND_BOOT,
      ND_GUARD,
      ND_RUN
   } fsw_node_e;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } fsw_bus_req_s;

   typedef struct packed {
      logic [15:0] mult;
      logic [15:0] link_time;
      logic [15:0] local_time;
   } fsw_wd_cfg_s;

   typedef struct packed {
      logic mbx_allow;
      logic foe_only;
      logic pd_allow;
   } fsw_comm_s;

endpackage

//--- fsw_tick_gen.sv
// Shared watchdog tick prescaler
`timescale 1ns/100ps
module fsw_tick_gen (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [15:0] mult,
   output logic tick
);
   import fsw_pkg::*;

   // ----------------------------------------------------------------
   // Fractional accumulator in half base periods
   // ----------------------------------------------------------------
   // Core clock is slower than the base clock, so whole periods cannot be
   // counted; the remainder carries over and the average rate stays exact.
   logic [17:0] acc_q;
   logic [17:0] acc_d;
   logic [17:0] limit;
   logic [17:0] sum;
   logic hit;

   assign limit = {1'b0, mult, 1'b0} + HALF_TICK_EXTRA;
   assign sum = acc_q + HALF_BASE_PER_CLK;
   assign hit = sum >= limit;
   assign acc_d = hit ? sum - limit : sum;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         acc_q <= 18'h0;
         tick <= 1'b0;
      end else begin
         acc_q <= acc_d;
         tick <= hit;
      end
   end

endmodule

//--- fsw_wd_timer.sv
// One watchdog timer counting shared ticks
`timescale 1ns/100ps
module fsw_wd_timer (
   input wire logic clk,
   input wire logic rstn,
   input wire logic tick,
   input wire logic kick,
   input wire logic [15:0] limit,
   output logic trip
);
   import fsw_pkg::*;

   // ----------------------------------------------------------------
   // Tick counter
   // ----------------------------------------------------------------
   logic [15:0] cnt_q;
   logic [16:0] cnt_inc;
   logic enabled;
   logic expire;

   assign enabled = limit != 16'h0;
   assign cnt_inc = {1'b0, cnt_q} + 17'h1;
   assign expire = tick && (cnt_inc >= {1'b0, limit});

   always_ff @(posedge clk) begin
      if (!rstn) begin
         cnt_q <= 16'h0;
         trip <= 1'b0;
      end else if (!enabled || kick) begin
         cnt_q <= 16'h0;
         trip <= 1'b0;
      end else if (!trip && tick) begin
         if (expire) begin
            trip <= 1'b1;
         end else begin
            cnt_q <= cnt_inc[15:0];
         end
      end
   end

endmodule

//--- fsw_output_watchdog.sv
// Node state machine, watchdogs and output gating of the fieldbus slave
`timescale 1ns/100ps
// Contract
// - Successful data exchange restarts link watchdog
// - Link timeout forces all outputs false
// - Trip keeps state; next exchange clears it
// - Both watchdogs default to 100 ms
// - Local side silence trips local watchdog
// - Tick is multiplier plus two base periods
// - Shared multiplier, own timer per watchdog
// - Defaults 2498 and 1000 give 100 ms
// - Timers 0..65535, multiplier 1..65535
// - Link timer zero disables the watchdog
// - Init after reset, no traffic allowed
// - Check mailbox entering preparation; mailbox only; code checks it from init only, not from guarded or running
// - Check data setup, copy inputs, then acknowledge
// - Guarded: full traffic, outputs held safe
// - Running copies master outputs to pins
// - Boot only from init; file access only
module fsw_output_watchdog (
   input wire logic clk,
   input wire logic rstn,
   input wire fsw_pkg::fsw_bus_req_s bus,
   output logic [31:0] rdata,
   input wire logic pd_exchange_ok,
   input wire logic local_access,
   input wire logic mbx_cfg_ok,
   input wire logic pd_cfg_ok,
   input wire logic dc_cfg_ok,
   input wire logic [31:0] out_data,
   input wire logic [31:0] in_pins,
   output logic [31:0] phys_out,
   output logic [31:0] in_image,
   output fsw_pkg::fsw_comm_s comm,
   output logic [3:0] node_code,
   output logic link_trip,
   output logic local_trip,
   output logic req_refused
);
   import fsw_pkg::*;

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   function automatic logic [3:0] state_code(input fsw_node_e s);
      logic [3:0] c;
      c = CODE_INIT;
      unique case (s)
         ND_INIT: c = CODE_INIT;
         ND_PREP: c = CODE_PREP;
         ND_BOOT: c = CODE_BOOT;
         ND_GUARD: c = CODE_GUARD;
         ND_RUN: c = CODE_RUN;
         default: c = CODE_INIT;
      endcase
      return c;
   endfunction

   function automatic logic code_valid(input logic [3:0] c);
      return (c == CODE_INIT) || (c == CODE_PREP) || (c == CODE_BOOT) ||
             (c == CODE_GUARD) || (c == CODE_RUN);
   endfunction

   function automatic fsw_node_e code_state(input logic [3:0] c);
      fsw_node_e s;
      s = ND_INIT;
      if (c == CODE_PREP) begin
         s = ND_PREP;
      end else if (c == CODE_BOOT) begin
         s = ND_BOOT;
      end else if (c == CODE_GUARD) begin
         s = ND_GUARD;
      end else if (c == CODE_RUN) begin
         s = ND_RUN;
      end
      return s;
   endfunction

   // Transition table with entry checks
   function automatic logic may_enter(input fsw_node_e cur, input fsw_node_e tgt,
                                      input logic mbx_ok, input logic pd_ok, input logic dc_ok);
      logic ok;
      ok = 1'b0;
      if (tgt == cur || tgt == ND_INIT) begin
         ok = 1'b1;
      end else begin
         unique case (cur)
            ND_INIT: ok = (tgt == ND_PREP) ? mbx_ok : (tgt == ND_BOOT);
            ND_PREP: ok = (tgt == ND_GUARD) && pd_ok && dc_ok;
            ND_GUARD: ok = (tgt == ND_RUN) || (tgt == ND_PREP);
            ND_RUN: ok = (tgt == ND_GUARD) || (tgt == ND_PREP);
            ND_BOOT: ok = 1'b0;
            default: ok = 1'b0;
         endcase
      end
      return ok;
   endfunction

   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   fsw_wd_cfg_s cfg_q;
   logic [3:0] req_code_q;
   logic req_pending_q;
   logic refused_q;
   logic [31:0] rdata_mux;
   logic wr_mult;
   logic wr_link;
   logic wr_local;
   logic wr_req;
   logic wr_status;
   logic [15:0] mult_wr_val;

   assign wr_mult = bus.wr && bus.addr == REG_WD_MULT;
   assign wr_link = bus.wr && bus.addr == REG_LINK_WD_TIME;
   assign wr_local = bus.wr && bus.addr == REG_LOCAL_WD_TIME;
   assign wr_req = bus.wr && bus.addr == REG_STATE_REQ;
   assign wr_status = bus.wr && bus.addr == REG_STATUS;
   // Multiplier below its floor would ask for ticks faster than the core clock can give
   assign mult_wr_val = (bus.wdata[15:0] < MIN_WD_MULT) ? MIN_WD_MULT : bus.wdata[15:0];

   // Settings are taken whenever written; the master writes them only at startup
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cfg_q.mult <= DEF_WD_MULT;
         cfg_q.link_time <= DEF_LINK_WD_TIME;
         cfg_q.local_time <= DEF_LOCAL_WD_TIME;
      end else begin
         if (wr_mult) begin
            cfg_q.mult <= mult_wr_val;
         end
         if (wr_link) begin
            cfg_q.link_time <= bus.wdata[15:0];
         end
         if (wr_local) begin
            cfg_q.local_time <= bus.wdata[15:0];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         req_code_q <= CODE_INIT;
         req_pending_q <= 1'b0;
      end else if (wr_req) begin
         req_code_q <= bus.wdata[3:0];
         req_pending_q <= 1'b1;
      end else begin
         req_pending_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Watchdogs
   // ----------------------------------------------------------------
   logic wd_tick;
   logic link_trip_w;
   logic local_trip_w;
   logic link_kick;

   fsw_tick_gen u_tick (
      .clk(clk),
      .rstn(rstn),
      .mult(cfg_q.mult),
      .tick(wd_tick)
   );

   fsw_wd_timer u_link_wd (
      .clk(clk),
      .rstn(rstn),
      .tick(wd_tick),
      .kick(link_kick),
      .limit(cfg_q.link_time),
      .trip(link_trip_w)
   );

   fsw_wd_timer u_local_wd (
      .clk(clk),
      .rstn(rstn),
      .tick(wd_tick),
      .kick(local_access),
      .limit(cfg_q.local_time),
      .trip(local_trip_w)
   );

   // ----------------------------------------------------------------
   // Node state machine
   // ----------------------------------------------------------------
   fsw_node_e node_q;
   fsw_node_e node_d;
   fsw_node_e req_state;
   logic req_ok;
   logic req_bad;
   logic enter_guard;

   assign req_state = code_state(req_code_q);
   assign req_ok = req_pending_q && code_valid(req_code_q) &&
                   may_enter(node_q, req_state, mbx_cfg_ok, pd_cfg_ok, dc_cfg_ok);
   assign req_bad = req_pending_q && !req_ok;
   assign node_d = req_ok ? req_state : node_q;
   assign enter_guard = req_ok && node_q == ND_PREP && req_state == ND_GUARD;

   // Watchdog trips never move the node; only master requests do
   always_ff @(posedge clk) begin
      if (!rstn) begin
         node_q <= ND_INIT;
      end else begin
         node_q <= node_d;
      end
   end

   // Refusal is sticky; a refusal in the clearing cycle survives
   always_ff @(posedge clk) begin
      if (!rstn) begin
         refused_q <= 1'b0;
      end else if (req_bad) begin
         refused_q <= 1'b1;
      end else if (wr_status && bus.wdata[ST_REFUSED_BIT]) begin
         refused_q <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Traffic permissions
   // ----------------------------------------------------------------
   fsw_comm_s comm_d;
   logic pd_state;
   logic pd_next;

   // Permissions follow the state being entered, so they never lag node_code
   assign pd_state = node_q == ND_GUARD || node_q == ND_RUN;
   assign pd_next = node_d == ND_GUARD || node_d == ND_RUN;
   assign comm_d.mbx_allow = node_d != ND_INIT;
   assign comm_d.foe_only = node_d == ND_BOOT;
   assign comm_d.pd_allow = pd_next;
   // Refused process data does not feed the watchdog
   assign link_kick = pd_exchange_ok && pd_state;

   // ----------------------------------------------------------------
   // Input sampling and image
   // ----------------------------------------------------------------
   logic [31:0] in_s1_q;
   logic [31:0] in_s2_q;
   logic [31:0] in_s3_q;
   logic [31:0] in_stable_q;
   logic [31:0] in_stable_d;
   logic [31:0] in_image_d;

   // A bit changes only once the second and third stages agree
   assign in_stable_d = (in_s2_q & in_s3_q) | (in_stable_q & (in_s2_q ^ in_s3_q));
   assign in_image_d = (enter_guard || link_kick) ? in_stable_q : in_image;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         in_s1_q <= 32'h0;
         in_s2_q <= 32'h0;
         in_s3_q <= 32'h0;
         in_stable_q <= 32'h0;
         in_image <= 32'h0;
      end else begin
         in_s1_q <= in_pins;
         in_s2_q <= in_s1_q;
         in_s3_q <= in_s2_q;
         in_stable_q <= in_stable_d;
         in_image <= in_image_d;
      end
   end

   // ----------------------------------------------------------------
   // Output image and safe gating
   // ----------------------------------------------------------------
   logic [31:0] out_image_q;
   logic drive_ok;
   logic [31:0] phys_out_d;

   // Master data is latched only by a real exchange, never a refused one
   assign drive_ok = node_d == ND_RUN && !link_trip_w && !local_trip_w;
   assign phys_out_d = drive_ok ? out_image_q : 32'h0;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         out_image_q <= 32'h0;
         phys_out <= 32'h0;
      end else begin
         if (link_kick) begin
            out_image_q <= out_data;
         end
         phys_out <= phys_out_d;
      end
   end

   // ----------------------------------------------------------------
   // Status outputs and read port
   // ----------------------------------------------------------------
   logic [31:0] status_word;

   always_comb begin
      status_word = 32'h0;
      status_word[ST_CODE_LSB +: ST_CODE_W] = state_code(node_q);
      status_word[ST_LINK_TRIP_BIT] = link_trip_w;
      status_word[ST_LOCAL_TRIP_BIT] = local_trip_w;
      status_word[ST_REFUSED_BIT] = refused_q;
   end

   always_comb begin
      rdata_mux = 32'h0;
      unique case (bus.addr)
         REG_WD_MULT: rdata_mux = {16'h0, cfg_q.mult};
         REG_LINK_WD_TIME: rdata_mux = {16'h0, cfg_q.link_time};
         REG_LOCAL_WD_TIME: rdata_mux = {16'h0, cfg_q.local_time};
         REG_STATE_REQ: rdata_mux = {28'h0, req_code_q};
         REG_STATUS: rdata_mux = status_word;
         REG_INPUT_IMAGE: rdata_mux = in_image;
         default: rdata_mux = 32'h0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         rdata <= 32'h0;
         comm <= '0;
         node_code <= CODE_INIT;
         link_trip <= 1'b0;
         local_trip <= 1'b0;
         req_refused <= 1'b0;
      end else begin
         rdata <= bus.rd ? rdata_mux : 32'h0;
         comm <= comm_d;
         node_code <= state_code(node_d);
         link_trip <= link_trip_w;
         local_trip <= local_trip_w;
         req_refused <= refused_q || req_bad;
      end
   end

endmodule

//--- fsw_output_watchdog_properties.sv
// Port-level assertions for the output watchdog block
`timescale 1ns/100ps
module fsw_output_watchdog_properties (
   input wire logic clk,
   input wire logic rstn,
   input wire fsw_pkg::fsw_bus_req_s bus,
   input wire logic pd_exchange_ok,
   input wire logic mbx_cfg_ok,
   input wire logic pd_cfg_ok,
   input wire logic dc_cfg_ok,
   input wire logic [31:0] phys_out,
   input wire fsw_pkg::fsw_comm_s comm,
   input wire logic [3:0] node_code,
   input wire logic link_trip,
   input wire logic local_trip,
   input wire logic req_refused
);
   import fsw_pkg::*;
   // ------------
   // Request sequence
   // ------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   sequence s_req(logic [3:0] code, logic [3:0] from);
      bus.wr && bus.addr == REG_STATE_REQ && bus.wdata[3:0] == code && node_code == from;
   endsequence
   // ------------
   // Properties
   // ------------
   AST_RESET_STATE: assert property (
      $rose(rstn) |-> node_code == CODE_INIT && comm == 3'h0 && phys_out == 32'h0)
      else $error("outputs not reset");
   AST_INIT_QUIET: assert property (node_code == CODE_INIT |-> comm == 3'h0)
      else $error("traffic allowed in init");
   AST_PREP_MBX: assert property (node_code == CODE_PREP |-> comm == 3'h4)
      else $error("wrong traffic in preparation");
   AST_BOOT_FILE: assert property (node_code == CODE_BOOT |-> comm == 3'h6)
      else $error("wrong traffic in boot");
   AST_BOOT_ENTRY: assert property (
      node_code == CODE_BOOT && $past(node_code) != CODE_BOOT |-> $past(node_code) == CODE_INIT)
      else $error("boot entered from wrong state");
   AST_GUARD_SAFE: assert property (
      node_code == CODE_GUARD && $past(node_code) == CODE_GUARD |-> phys_out == 32'h0 && comm == 3'h5)
      else $error("guarded state not safe");
   AST_LINK_SAFE: assert property (link_trip |-> phys_out == 32'h0)
      else $error("outputs driven after link trip");
   AST_LOCAL_SAFE: assert property (local_trip ##1 local_trip |-> phys_out == 32'h0)
      else $error("outputs driven after local trip");
   AST_TRIP_STATE: assert property ($rose(link_trip) |-> $stable(node_code))
      else $error("trip changed node state");
   AST_KICK_CLEAR: assert property (
      link_trip && pd_exchange_ok && (node_code == CODE_GUARD || node_code == CODE_RUN) |-> ##[1:2] !link_trip)
      else $error("exchange did not clear trip");
   AST_REFUSE: assert property (
      s_req(CODE_GUARD, CODE_INIT) |-> ##2 req_refused && node_code == CODE_INIT)
      else $error("illegal request not refused");
   AST_PREP_ENTRY: assert property (
      s_req(CODE_PREP, CODE_INIT) ##0 mbx_cfg_ok |-> ##2 node_code == CODE_PREP)
      else $error("preparation not entered");
   AST_GUARD_ENTRY: assert property (
      s_req(CODE_GUARD, CODE_PREP) ##0 (pd_cfg_ok && dc_cfg_ok) |-> ##2 node_code == CODE_GUARD)
      else $error("guarded not entered");
endmodule
bind fsw_output_watchdog fsw_output_watchdog_properties chk_u (.clk(clk), .rstn(rstn), .bus(bus),
   .pd_exchange_ok(pd_exchange_ok), .mbx_cfg_ok(mbx_cfg_ok), .pd_cfg_ok(pd_cfg_ok), .dc_cfg_ok(dc_cfg_ok),
   .phys_out(phys_out), .comm(comm), .node_code(node_code), .link_trip(link_trip), .local_trip(local_trip),
   .req_refused(req_refused));

//--- fsw_master_model.sv
// Behavioural fieldbus master issuing cyclic exchanges
`timescale 1ns/100ps
module fsw_master_model (
   input wire logic clk,
   input wire logic rstn,
   input wire logic run,
   input wire logic [3:0] gap,
   output logic pd_exchange_ok,
   output logic [31:0] out_data,
   output logic [31:0] sent
);
   logic [3:0] cnt_q;
   // ------------
   // Exchange generator
   // ------------
   // Bus shows the inverse between exchanges so stale data cannot pass
   always_ff @(posedge clk) begin
      cnt_q <= (!rstn || !run || cnt_q == gap) ? 4'h0 : cnt_q + 4'h1;
      pd_exchange_ok <= rstn && run && cnt_q == gap;
      if (!rstn) begin
         sent <= 32'h5a3c0000;
         out_data <= 32'ha5c3ffff;
      end else if (run && cnt_q == gap) begin
         sent <= sent + 32'h00110011;
         out_data <= sent + 32'h00110011;
      end else begin
         out_data <= ~sent;
      end
   end
endmodule

//--- fsw_output_watchdog_tb.sv
// Self-checking testbench of the output watchdog block
`timescale 1ns/100ps
module fsw_output_watchdog_tb;
   import fsw_pkg::*;
   // ------------
   // Signals and instances
   // ------------
   // Short ticks keep the timeouts within a few dozen cycles
   localparam int MULT = 8;
   localparam int LINK_T = 5;
   localparam int LOCAL_T = 3;
   logic clk, rstn, pd_ok, loc_acc, loc_en, mbx_ok, pd_cfg, dc_cfg, run;
   logic link_trip, local_trip, req_refused;
   logic [31:0] rdata, out_data, in_pins, phys_out, in_image, sent;
   logic [3:0] node_code;
   fsw_bus_req_s bus;
   fsw_comm_s comm;
   int fails = 0;
   int samples_checked = 0;
   fsw_output_watchdog dut_u (.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata), .pd_exchange_ok(pd_ok),
      .local_access(loc_acc), .mbx_cfg_ok(mbx_ok), .pd_cfg_ok(pd_cfg), .dc_cfg_ok(dc_cfg), .out_data(out_data),
      .in_pins(in_pins), .phys_out(phys_out), .in_image(in_image), .comm(comm), .node_code(node_code),
      .link_trip(link_trip), .local_trip(local_trip), .req_refused(req_refused));
   fsw_master_model master_u (.clk(clk), .rstn(rstn), .run(run), .gap(4'h9), .pd_exchange_ok(pd_ok),
      .out_data(out_data), .sent(sent));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Local side access every other cycle while enabled
   always @(posedge clk) loc_acc <= rstn && loc_en && !loc_acc;
   // ------------
   // Helpers
   // ------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize;
      $display("Checks %0d, mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk);
      bus <= '{a, d, 1'b0, 1'b0};
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      bus <= '{a, 32'h0, 1'b0, 1'b1};
      @(posedge clk);
      bus <= '{a, 32'h0, 1'b0, 1'b0};
      #1 chk(rdata, e);
   endtask
   task automatic req(input logic [3:0] c);
      wr(REG_STATE_REQ, 32'(c));
      @(posedge clk);
      #1;
   endtask
   task automatic count_to(ref logic s, output int n);
      n = 0;
      do begin
         @(posedge clk);
         #1 n++;
      end while (s !== 1'b1 && n < 400);
      if (n >= 400) begin
         fails++;
         summarize;
      end
   endtask
   task automatic sync_ex;
      int n;
      count_to(pd_ok, n);
      repeat (3) @(posedge clk);
      #1;
   endtask
   function automatic int wd_cycles(input int t);
      return t * (MULT + 2) * int'(BASE_PERIOD_NS) / int'(CLK_PERIOD_NS);
   endfunction
   // ------------
   // Scenarios
   // ------------
   task automatic t_regs;
      rc(REG_WD_MULT, 32'(DEF_WD_MULT));
      rc(REG_LINK_WD_TIME, 32'(DEF_LINK_WD_TIME));
      rc(REG_LOCAL_WD_TIME, 32'(DEF_LOCAL_WD_TIME));
      rc(REG_STATUS, 32'(CODE_INIT));
      rc(8'h40, 32'h0);
      wr(REG_WD_MULT, 32'h0);
      rc(REG_WD_MULT, 32'(MIN_WD_MULT));
      wr(REG_LINK_WD_TIME, 32'hffff);
      rc(REG_LINK_WD_TIME, 32'hffff);
      wr(REG_WD_MULT, 32'h12340000 | 32'(MULT));
      wr(REG_LINK_WD_TIME, 32'(LINK_T));
      wr(REG_LOCAL_WD_TIME, 32'(LOCAL_T));
      rc(REG_WD_MULT, 32'(MULT));
      rc(REG_LOCAL_WD_TIME, 32'(LOCAL_T));
      // Let the idle link watchdog trip before any state change
      repeat (40) @(posedge clk);
      $display("Test registers done");
   endtask
   task automatic t_states;
      req(CODE_GUARD);
      chk(32'(node_code), 32'(CODE_INIT));
      chk(32'(req_refused), 32'h1);
      wr(REG_STATUS, 32'h40);
      @(posedge clk);
      #1 chk(32'(req_refused), 32'h0);
      req(CODE_BOOT);
      chk(32'(comm), 32'h6);
      req(CODE_PREP);
      chk(32'(node_code), 32'(CODE_BOOT));
      req(CODE_INIT);
      req(CODE_PREP);
      chk(32'(node_code), 32'(CODE_INIT));
      @(posedge clk) mbx_ok <= 1'b1;
      req(CODE_PREP);
      chk(32'(comm), 32'h4);
      req(CODE_BOOT);
      chk(32'(node_code), 32'(CODE_PREP));
      @(posedge clk) pd_cfg <= 1'b1;
      req(CODE_GUARD);
      chk(32'(node_code), 32'(CODE_PREP));
      @(posedge clk) dc_cfg <= 1'b1;
      req(CODE_GUARD);
      chk(in_image, in_pins);
      rc(REG_INPUT_IMAGE, in_pins);
      chk(32'(comm), 32'h5);
      run <= 1'b1;
      sync_ex;
      chk(phys_out, 32'h0);
      chk(32'(link_trip), 32'h0);
      req(CODE_RUN);
      sync_ex;
      chk(32'(node_code), 32'(CODE_RUN));
      chk(phys_out, sent);
      $display("Test node states done");
   endtask
   task automatic t_watchdogs;
      int n;
      count_to(pd_ok, n);
      run <= 1'b0;
      count_to(link_trip, n);
      chk(32'(n >= wd_cycles(LINK_T) - 1 && n <= wd_cycles(LINK_T) + 3), 32'h1);
      chk(phys_out, 32'h0);
      chk(32'(node_code), 32'(CODE_RUN));
      rc(REG_STATUS, 32'h50 | 32'(CODE_RUN));
      run <= 1'b1;
      repeat (60) @(posedge clk);
      sync_ex;
      chk(32'(link_trip), 32'h0);
      chk(phys_out, sent);
      loc_en <= 1'b0;
      count_to(local_trip, n);
      chk(32'(n >= wd_cycles(LOCAL_T) - 2 && n <= wd_cycles(LOCAL_T) + 3), 32'h1);
      chk(phys_out, 32'h0);
      loc_en <= 1'b1;
      sync_ex;
      chk(32'(local_trip), 32'h0);
      $display("Test watchdogs done");
   endtask
   task automatic t_disable;
      int n;
      wr(REG_LINK_WD_TIME, 32'h0);
      count_to(pd_ok, n);
      run <= 1'b0;
      repeat (200) @(posedge clk);
      #1 chk(32'(link_trip), 32'h0);
      chk(phys_out, sent);
      req(CODE_GUARD);
      @(posedge clk);
      #1 chk(phys_out, 32'h0);
      $display("Test disable done");
   endtask
   // ------------
   // Main sequence
   // ------------
   initial begin
      rstn = 1'b0;
      bus = '0;
      mbx_ok = 1'b0;
      pd_cfg = 1'b0;
      dc_cfg = 1'b0;
      run = 1'b0;
      loc_en = 1'b1;
      in_pins = 32'h00c3a517;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      t_regs;
      t_states;
      t_watchdogs;
      t_disable;
      summarize;
   end
endmodule
